//--- design/ppsc_pkg.sv
// Package with command decode constants and power-on values of the serial control block.
package ppsc_pkg;
  // Command byte layout.
  localparam int unsigned CMD_W = 8;
  localparam int unsigned PTR_MSB = 7;
  localparam int unsigned PTR_LO = 5;
  localparam logic [1:0] PTR_POWER = 2'h0;
  localparam logic [1:0] PTR_BACKUP = 2'h1;
  localparam logic [1:0] PTR_VOLTAGE = 2'h2;
  localparam logic [1:0] PTR_NONE = 2'h3;
  // Pointer 000 field positions.
  localparam int unsigned PWR_RUN_BIT = 0;
  localparam int unsigned PWR_REG2_BIT = 1;
  localparam int unsigned PWR_REG3_BIT = 2;
  localparam int unsigned PWR_SW1_BIT = 3;
  localparam int unsigned PWR_SW2_BIT = 4;
  // Pointer 001 field positions.
  localparam int unsigned BK_LOWCHG_BIT = 0;
  localparam int unsigned BK_HIGHCHG_BIT = 1;
  localparam int unsigned BK_BACKUP_BIT = 2;
  localparam int unsigned BK_TRIG_BIT = 3;
  // Power-on values.
  localparam logic [4:0] POWER_POR = 5'h00;
  localparam logic [3:0] BACKUP_POR = 4'h0;
  localparam logic [4:0] VOLTAGE_POR = 5'h0c;
  localparam logic [6:0] THRESH_POR = 7'h00;
  localparam logic [2:0] RESULTS_POR = 3'h0;
  // Serial return byte: channel results in bits 7..5, low battery in bit 4.
  localparam logic [3:0] STATUS_LOW_FILL = 4'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : ppsc_pkg

//--- design/ppsc_serial_control.sv
// Serial control block: shift-clock receiver, command decode, control fields and status return.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Supply-below-threshold reset input forces every control field to its power-on value.
// - Reset-detector low during operation also returns all fields to power-on values.
// - After any reset the power mode is coast until run is requested.
// - Charger gives high or low current; high wins when both enabled.
// - Command byte is 3-bit pointer then 5 data bits; pointer 000 fields.
// - Pointer 001 holds auto-backup, backup, high charge, low charge; bit 4 ignored.
// - Pointer 010 holds output voltage code, power-on value 01100.
// - Command MSB set loads the lower seven bits as threshold code.
// - Threshold resets to zero; zero code turns the comparators off.
// - Backup regulator on disables step-up converter and charger only.
// - Auto-backup bit lets a low battery turn backup on by itself.
// - Backup enable forces backup on and charger off regardless of others.
// - Power mode bit one means run, zero means coast.
// - Regulator and switch enables turn things on at one, reset off.
// - MSB first; input sampled on rising, output changed on falling edge.
// - Chip select low shows D7 at once; next bit after first rising edge.
// - Each transfer returns channel 2, 1, 0 results and low battery, low nibble zero.
// - Result is one when channel exceeds threshold; low battery when input below.
// - Returned channel results belong to the threshold of the previous write.
// - Run mode when mode bit or run pin high; coast when both low.
// - Switch two needs its enable and tone gate high; switch one enable only.
module ppsc_serial_control (
  input wire logic clock,
  input wire logic srst,
  input wire logic shift_clock,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_return,
  input wire logic supply_below_por,
  input wire logic reset_detect_flag_n,
  input wire logic run_request_pin,
  input wire logic tone_gate_input,
  input wire logic low_battery_below,
  input wire logic channel0_above,
  input wire logic channel1_above,
  input wire logic channel2_above,
  output logic run_mode_q,
  output logic analog_regulator_enable_q,
  output logic third_regulator_enable_q,
  output logic open_drain_switch_one_q,
  output logic open_drain_switch_two_q,
  output logic high_charge_on_q,
  output logic low_charge_on_q,
  output logic reserve_regulator_on_q,
  output logic step_up_enable_q,
  output logic [4:0] supply_voltage_code_q,
  output logic [6:0] compare_threshold_code_q,
  output logic comparators_on_q
);

  // Link side, clocked by the host's shift clock.
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] rx_byte_q;
  logic rx_toggle_q;
  logic seen_rise_q;
  logic [2:0] out_idx_q;

  // Deselect clears the bit count, so a partial byte never reaches the decoder.
  always_ff @(posedge shift_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_q <= 3'h0;
      seen_rise_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      seen_rise_q <= 1'b1;
    end
  end

  always_ff @(posedge shift_clock) begin
    shift_q <= {shift_q[5:0], serial_data_in};
    if (bit_cnt_q == ppsc_pkg::LAST_BIT) begin
      rx_byte_q <= {shift_q, serial_data_in};
    end
  end

  // The toggle only flips on a complete byte; the byte register then holds still
  // for at least seven more shift edges, which covers the crossing delay.
  always_ff @(posedge shift_clock or posedge srst) begin
    if (srst) begin
      rx_toggle_q <= 1'b0;
    end else if (!chip_select_n && bit_cnt_q == ppsc_pkg::LAST_BIT) begin
      rx_toggle_q <= ~rx_toggle_q;
    end
  end

  // Output index moves on falling edges, and only once a rising edge was seen.
  always_ff @(negedge shift_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_idx_q <= 3'h0;
    end else if (seen_rise_q) begin
      out_idx_q <= out_idx_q + 3'h1;
    end
  end

  // System side.
  logic [1:0] tog_s_q;
  logic tog_seen_q;
  logic [1:0] cs_s_q;
  logic [1:0] por_s_q;
  logic [1:0] rsd_s_q;
  logic [1:0] run_s_q;
  logic [1:0] tone_s_q;
  logic [1:0] lowb_s_q;
  logic [1:0] ch0_s_q;
  logic [1:0] ch1_s_q;
  logic [1:0] ch2_s_q;
  logic fields_reset;
  logic apply;
  logic [4:0] power_q;
  logic [3:0] backup_ctl_q;
  logic backup_now;
  logic [7:0] status_hold_q;

  // Backup is wanted when asked for directly, or when armed and the battery is low.
  function automatic logic backup_wanted(input logic [3:0] ctl, input logic batt_low);
    return ctl[ppsc_pkg::BK_BACKUP_BIT] | (ctl[ppsc_pkg::BK_TRIG_BIT] & batt_low);
  endfunction : backup_wanted

  // A pointer command has its top bit clear and its pointer field equal to ptr.
  function automatic logic ptr_hit(input logic [7:0] cmd, input logic [1:0] ptr);
    return !cmd[ppsc_pkg::PTR_MSB] && (cmd[6:5] == ptr);
  endfunction : ptr_hit

  always_ff @(posedge clock) begin
    tog_s_q <= {tog_s_q[0], rx_toggle_q};
    cs_s_q <= {cs_s_q[0], chip_select_n};
    por_s_q <= {por_s_q[0], supply_below_por};
    rsd_s_q <= {rsd_s_q[0], reset_detect_flag_n};
    run_s_q <= {run_s_q[0], run_request_pin};
    tone_s_q <= {tone_s_q[0], tone_gate_input};
    lowb_s_q <= {lowb_s_q[0], low_battery_below};
    ch0_s_q <= {ch0_s_q[0], channel0_above};
    ch1_s_q <= {ch1_s_q[0], channel1_above};
    ch2_s_q <= {ch2_s_q[0], channel2_above};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tog_seen_q <= 1'b0;
    end else begin
      tog_seen_q <= tog_s_q[1];
    end
  end

  assign apply = tog_s_q[1] ^ tog_seen_q;
  // Both the supply monitor and the reset detector act like the system reset on the control fields, but not on the link toggle or the snapshot.
  assign fields_reset = srst | por_s_q[1] | ~rsd_s_q[1];

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      power_q <= ppsc_pkg::POWER_POR;
    end else if (apply && ptr_hit(rx_byte_q, ppsc_pkg::PTR_POWER)) begin
      power_q <= rx_byte_q[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      backup_ctl_q <= ppsc_pkg::BACKUP_POR;
    end else if (apply && ptr_hit(rx_byte_q, ppsc_pkg::PTR_BACKUP)) begin
      backup_ctl_q <= rx_byte_q[3:0];
    end
  end

  // Pointer 011 matches none of the loads, so it leaves every field alone.
  always_ff @(posedge clock) begin
    if (fields_reset) begin
      supply_voltage_code_q <= ppsc_pkg::VOLTAGE_POR;
    end else if (apply && ptr_hit(rx_byte_q, ppsc_pkg::PTR_VOLTAGE)) begin
      supply_voltage_code_q <= rx_byte_q[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      compare_threshold_code_q <= ppsc_pkg::THRESH_POR;
    end else if (apply && rx_byte_q[ppsc_pkg::PTR_MSB]) begin
      compare_threshold_code_q <= rx_byte_q[6:0];
    end
  end

  // The snapshot follows the comparators while deselected and freezes while selected,
  // so a read shows the comparison against the code that the previous write left.
  // Select must stay high for a few system clocks between frames for it to refresh.
  always_ff @(posedge clock) begin
    if (srst) begin
      status_hold_q <= 8'h00;
    end else if (cs_s_q[1]) begin
      status_hold_q <= {(comparators_on_q ? {ch2_s_q[1], ch1_s_q[1], ch0_s_q[1]} : ppsc_pkg::RESULTS_POR),
                        lowb_s_q[1], ppsc_pkg::STATUS_LOW_FILL};
    end
  end

  // Bit D7 must appear the moment select falls, before any shift edge, so the
  // pin is a select from the frozen snapshot rather than a shift-clock flop.
  assign serial_data_return = status_hold_q[ppsc_pkg::LAST_BIT - out_idx_q];

  // One shared term, so the regulator, the step-up enable and the charger gates
  // can never disagree about whether backup is on.
  assign backup_now = backup_wanted(backup_ctl_q, lowb_s_q[1]);

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      run_mode_q <= 1'b0;
    end else begin
      run_mode_q <= power_q[ppsc_pkg::PWR_RUN_BIT] | run_s_q[1];
    end
  end

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      analog_regulator_enable_q <= 1'b0;
      third_regulator_enable_q <= 1'b0;
    end else begin
      analog_regulator_enable_q <= power_q[ppsc_pkg::PWR_REG2_BIT];
      third_regulator_enable_q <= power_q[ppsc_pkg::PWR_REG3_BIT];
    end
  end

  // Switch two sees the tone gate through its synchroniser, so a beeper tone on
  // that pin must stay far below the system clock rate.
  always_ff @(posedge clock) begin
    if (fields_reset) begin
      open_drain_switch_one_q <= 1'b0;
      open_drain_switch_two_q <= 1'b0;
    end else begin
      open_drain_switch_one_q <= power_q[ppsc_pkg::PWR_SW1_BIT];
      open_drain_switch_two_q <= power_q[ppsc_pkg::PWR_SW2_BIT] & tone_s_q[1];
    end
  end

  // Backup takes only the step-up converter and the charger down with it.
  always_ff @(posedge clock) begin
    if (fields_reset) begin
      reserve_regulator_on_q <= 1'b0;
      step_up_enable_q <= 1'b1;
    end else begin
      reserve_regulator_on_q <= backup_now;
      step_up_enable_q <= ~backup_now;
    end
  end

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      high_charge_on_q <= 1'b0;
      low_charge_on_q <= 1'b0;
    end else begin
      high_charge_on_q <= backup_ctl_q[ppsc_pkg::BK_HIGHCHG_BIT] & ~backup_now;
      low_charge_on_q <= backup_ctl_q[ppsc_pkg::BK_LOWCHG_BIT]
        & ~backup_ctl_q[ppsc_pkg::BK_HIGHCHG_BIT] & ~backup_now;
    end
  end

  always_ff @(posedge clock) begin
    if (fields_reset) begin
      comparators_on_q <= 1'b0;
    end else begin
      comparators_on_q <= |compare_threshold_code_q;
    end
  end

endmodule : ppsc_serial_control

`default_nettype wire

//--- sim/ppsc_host_model.sv
// Host-side serial master model that drives one frame per call.
`timescale 1ns/1ps
`default_nettype none
module ppsc_host_model (
  output logic shift_clock,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_return
);
  // The link counters clear only on a rising select, so give them one before any frame.
  initial begin
    shift_clock = 1'b0;
    chip_select_n = 1'b0;
    serial_data_in = 1'b0;
    #1;
    chip_select_n = 1'b1;
  end
  // Sends the top nbits of cmd on a 30 ns shift clock that stands still between frames.
  task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] ret);
    ret = 8'h00;
    chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = cmd[7 - i];
      #15 shift_clock = 1'b1;
      ret = {ret[6:0], serial_data_return};
      #15 shift_clock = 1'b0;
    end
    #15 chip_select_n = 1'b1;
    // A released line keeps no level, so it shows the opposite one.
    serial_data_in = ~serial_data_in;
    #120;
  endtask : xfer
endmodule : ppsc_host_model
`default_nettype wire

//--- sim/ppsc_serial_control_properties.sv
// Checker for the control outputs of the serial control block.
`timescale 1ns/1ps
`default_nettype none
module ppsc_serial_control_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic supply_below_por,
  input wire logic reset_detect_flag_n,
  input wire logic run_request_pin,
  input wire logic tone_gate_input,
  input wire logic run_mode_q,
  input wire logic analog_regulator_enable_q,
  input wire logic open_drain_switch_two_q,
  input wire logic high_charge_on_q,
  input wire logic low_charge_on_q,
  input wire logic reserve_regulator_on_q,
  input wire logic step_up_enable_q,
  input wire logic [4:0] supply_voltage_code_q,
  input wire logic [6:0] compare_threshold_code_q,
  input wire logic comparators_on_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_step_up; step_up_enable_q == !reserve_regulator_on_q; endproperty
  a_step_up: assert property (p_step_up) else $error("step-up not opposite to backup");
  property p_one_rate; !(high_charge_on_q && low_charge_on_q); endproperty
  a_one_rate: assert property (p_one_rate) else $error("both charge rates on");
  property p_backup_stops; reserve_regulator_on_q |-> !high_charge_on_q && !low_charge_on_q; endproperty
  a_backup_stops: assert property (p_backup_stops) else $error("charger on during backup");
  property p_comp_on; $stable(compare_threshold_code_q)
    |-> comparators_on_q == (compare_threshold_code_q != 7'h00); endproperty
  a_comp_on: assert property (p_comp_on) else $error("comparator enable wrong");
  property p_supply_reset; $rose(supply_below_por) |-> ##[2:5]
    (compare_threshold_code_q == 7'h00 && supply_voltage_code_q == ppsc_pkg::VOLTAGE_POR); endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("supply reset missed");
  property p_detect_reset; $fell(reset_detect_flag_n) |-> ##[2:5]
    (!analog_regulator_enable_q && !open_drain_switch_two_q); endproperty
  a_detect_reset: assert property (p_detect_reset) else $error("detector reset missed");
  property p_coast; (supply_below_por && !run_request_pin) [*4] |=> !run_mode_q; endproperty
  a_coast: assert property (p_coast) else $error("run mode held in reset");
  property p_tone_gate; !tone_gate_input [*4] |=> !open_drain_switch_two_q; endproperty
  a_tone_gate: assert property (p_tone_gate) else $error("switch two on without gate");
  c_backup: cover property (reserve_regulator_on_q);
  c_comparators: cover property (comparators_on_q);
  c_run: cover property (run_mode_q);
endmodule : ppsc_serial_control_properties
bind ppsc_serial_control ppsc_serial_control_properties u_props (.*);
`default_nettype wire

//--- sim/ppsc_serial_control_tb.sv
// Self-checking testbench of the serial control block.
`timescale 1ns/1ps
`default_nettype none
module ppsc_serial_control_tb;
  logic clock, srst, shift_clock, chip_select_n, serial_data_in, serial_data_return, supply_below_por;
  logic reset_detect_flag_n, run_request_pin, tone_gate_input, low_battery_below, channel0_above;
  logic channel1_above, channel2_above, run_mode_q, analog_regulator_enable_q, third_regulator_enable_q;
  logic open_drain_switch_one_q, open_drain_switch_two_q, high_charge_on_q, low_charge_on_q;
  logic reserve_regulator_on_q, step_up_enable_q, comparators_on_q;
  logic [4:0] supply_voltage_code_q;
  logic [6:0] compare_threshold_code_q;
  logic [7:0] rb;
  int errors = 0;
  int checked = 0;
  ppsc_serial_control DUT (.*);
  ppsc_host_model host (.*);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic wait_cy(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cy
  // Fields land a few cycles after the last shift edge; eight cycles leave margin.
  task automatic wr(input logic [7:0] cmd);
    host.xfer(cmd, 8, rb);
    wait_cy(8);
  endtask : wr
  function automatic logic [7:0] pwr();
    return {3'h0, open_drain_switch_two_q, open_drain_switch_one_q, third_regulator_enable_q,
      analog_regulator_enable_q, run_mode_q};
  endfunction : pwr
  function automatic logic [7:0] bk();
    return {4'h0, reserve_regulator_on_q, step_up_enable_q, high_charge_on_q, low_charge_on_q};
  endfunction : bk
  task automatic t_power();
    chk(pwr(), 8'h00);
    chk(bk(), 8'h04);
    tone_gate_input = 1'b1;
    wr(8'h1f);
    chk(pwr(), 8'h1f);
    tone_gate_input = 1'b0;
    wait_cy(6);
    chk(pwr(), 8'h0f);
    wr(8'h00);
    run_request_pin = 1'b1;
    wait_cy(6);
    chk(pwr(), 8'h01);
    run_request_pin = 1'b0;
    wait_cy(6);
    chk(pwr(), 8'h00);
  endtask : t_power
  task automatic t_backup();
    logic [7:0] cmds [5] = '{8'h21, 8'h23, 8'h33, 8'h27, 8'h2b};
    logic [7:0] exps [5] = '{8'h05, 8'h06, 8'h06, 8'h08, 8'h06};
    for (int i = 0; i < 5; i++) begin
      wr(cmds[i]);
      chk(bk(), exps[i]);
    end
    low_battery_below = 1'b1;
    wait_cy(6);
    chk(bk(), 8'h08);
  endtask : t_backup
  task automatic t_status();
    chk({3'h0, supply_voltage_code_q}, 8'h0c);
    wr(8'hd5);
    chk(rb & 8'hf0, 8'h10);
    chk({1'b0, compare_threshold_code_q}, 8'h55);
    chk({7'h0, comparators_on_q}, 8'h01);
    wr(8'h7f);
    chk(rb & 8'hf0, 8'hb0);
    chk({3'h0, supply_voltage_code_q}, 8'h0c);
    channel1_above = 1'b1;
    channel2_above = 1'b0;
    wait_cy(4);
    wr(8'h7f);
    chk(rb & 8'hf0, 8'h70);
    wr(8'h53);
    chk({3'h0, supply_voltage_code_q}, 8'h13);
    host.xfer(8'h5f, 5, rb);
    wait_cy(8);
    chk({3'h0, supply_voltage_code_q}, 8'h13);
  endtask : t_status
  task automatic t_field_reset();
    supply_below_por = 1'b1;
    wait_cy(10);
    supply_below_por = 1'b0;
    wait_cy(8);
    chk({3'h0, supply_voltage_code_q}, 8'h0c);
    chk(bk(), 8'h04);
    wr(8'h1e);
    reset_detect_flag_n = 1'b0;
    wait_cy(10);
    reset_detect_flag_n = 1'b1;
    wait_cy(8);
    chk(pwr(), 8'h00);
  endtask : t_field_reset
  initial begin
    // The link toggle clears on a reset edge, so reset rises just after time zero.
    srst = 1'b0;
    supply_below_por = 1'b0;
    reset_detect_flag_n = 1'b1;
    run_request_pin = 1'b0;
    tone_gate_input = 1'b0;
    low_battery_below = 1'b0;
    channel0_above = 1'b1;
    channel1_above = 1'b0;
    channel2_above = 1'b1;
    #1;
    srst = 1'b1;
    wait_cy(5);
    srst = 1'b0;
    wait_cy(4);
    t_power();
    t_backup();
    t_status();
    t_field_reset();
    final_report();
  end
endmodule : ppsc_serial_control_tb
`default_nettype wire
